// file: rtl/fepc_core.v
// Purpose: two-stage fetch/execute pipeline, ALU and flags of an 8-bit core
// Assumes: program and data memories outside answer combinationally
// Notes: reduced opcode set; jump, MOVLW/ADDLW/SUBLW literal and listed register opcodes handled, others execute as no-op
`timescale 1ns/1ns
`include "fepc_defs.vh"
module fepc_core #(
    parameter PROG_AW = 11
) (
    input wire clk,
    input wire reset_n,
    input wire master_reset_n,
    input wire rc_mode,
    input wire int_request,
    input wire [`FEPC_IW-1:0] prog_rdata,
    input wire [`FEPC_DW-1:0] data_rdata,
    output reg [`FEPC_PC_W-1:0] prog_addr_r,
    output reg prog_rd_r,
    output reg [`FEPC_FA_W-1:0] data_addr_r,
    output reg data_rd_r,
    output reg data_wr_r,
    output reg [`FEPC_DW-1:0] data_wdata_r,
    output reg cycle_rate_output,
    output reg [`FEPC_DW-1:0] acc_operand_r,
    output reg [`FEPC_DW-1:0] status_r,
    output reg int_ack_r
);
    localparam [`FEPC_PC_W-1:0] PC_MASK = (13'h1 << PROG_AW) - 13'h1;
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // run control: a low master reset empties the pipeline
    wire [3:0] phase;
    reg state_r;
    reg run_r;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            run_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    run_r <= master_reset_n;
                    if (master_reset_n) state_r <= ST_RUN;
                end
                ST_RUN: begin
                    if (!master_reset_n) begin
                        run_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    fepc_phase_gen u_phase (
        .clk(clk),
        .reset_n(reset_n),
        .run(run_r & master_reset_n),
        .phase_r(phase)
    );
    wire ph1 = phase[`FEPC_PH1];
    wire ph2 = phase[`FEPC_PH2];
    wire ph4 = phase[`FEPC_PH4];

    ////////////////////////////////////////////////////////////////////////
    // fetch stage and pipeline registers
    reg [`FEPC_PC_W-1:0] prog_counter_r;
    reg [`FEPC_PC_W-1:0] pc_latch_r;
    reg [`FEPC_IW-1:0] fetch_buf_r;
    reg fetch_ok_r;
    reg [`FEPC_IW-1:0] fetched_word_latch;
    reg exec_ok_r;
    reg flush_r;
    reg [`FEPC_DW-1:0] operand_r;

    wire [5:0] opc = fetched_word_latch[`FEPC_OP_HI:`FEPC_OP_LO];
    wire is_jump = exec_ok_r && (fetched_word_latch[13:11] == `FEPC_JUMP_PFX);
    wire is_lit = exec_ok_r && (fetched_word_latch[13:12] == 2'h3);
    wire dest_f = fetched_word_latch[`FEPC_DBIT];
    wire [`FEPC_FA_W-1:0] faddr = fetched_word_latch[`FEPC_FA_W-1:0];
    wire [`FEPC_DW-1:0] lit = fetched_word_latch[`FEPC_DW-1:0];

    // literal opcodes carry don't-care low bits; compare only the bits that select
    function lit_match;
        input [5:0] op;
        input [5:0] code;
        input [5:0] care;
        begin
            lit_match = ((op ^ code) & care) == 6'h00;
        end
    endfunction

    // register opcodes of the reduced set; anything else must behave as a no-op
    function reg_op_ok;
        input [5:0] op;
        begin
            case (op)
                `FEPC_OP_MOVWF, `FEPC_OP_SUBWF, `FEPC_OP_ANDWF, `FEPC_OP_IORWF,
                `FEPC_OP_XORWF, `FEPC_OP_ADDWF, `FEPC_OP_MOVF, `FEPC_OP_COMF,
                `FEPC_OP_RRF, `FEPC_OP_RLF: reg_op_ok = 1'b1;
                default: reg_op_ok = 1'b0;
            endcase
        end
    endfunction

    wire lit_mov = is_lit && lit_match(opc, `FEPC_OP_MOVLW, `FEPC_LIT_MOV_CARE);
    wire lit_add = is_lit && lit_match(opc, `FEPC_OP_ADDLW, `FEPC_LIT_ARI_CARE);
    wire lit_sub = is_lit && lit_match(opc, `FEPC_OP_SUBLW, `FEPC_LIT_ARI_CARE);
    wire lit_ok = lit_mov || lit_add || lit_sub;
    wire reg_ok = exec_ok_r && !is_lit && !is_jump && reg_op_ok(opc);

    // file read mux: PCL and STATUS answer internally, the rest come from memory
    function [`FEPC_DW-1:0] file_rd;
        input [`FEPC_FA_W-1:0] a;
        input [`FEPC_PC_W-1:0] pc;
        input [`FEPC_DW-1:0] st;
        input [`FEPC_DW-1:0] mem;
        begin
            if (a == `FEPC_FA_PCL) file_rd = pc[`FEPC_DW-1:0];
            else if (a == `FEPC_FA_STATUS) file_rd = st;
            else file_rd = mem;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // ALU
    reg [`FEPC_DW-1:0] alu_y;
    reg alu_c, alu_dc, alu_c_upd, alu_z_upd, alu_wr, alu_mov;
    reg [`FEPC_DW-1:0] opa;
    reg [`FEPC_DW:0] sum;
    reg [4:0] nsum;
    always @* begin
        opa = is_lit ? lit : operand_r;
        sum = {1'b0, opa} + {1'b0, acc_operand_r};
        nsum = {1'b0, opa[3:0]} + {1'b0, acc_operand_r[3:0]};
        alu_y = opa;
        alu_c = status_r[`FEPC_ST_C];
        alu_dc = status_r[`FEPC_ST_DC];
        alu_c_upd = 1'b0;
        alu_z_upd = 1'b0;
        alu_wr = 1'b0;
        alu_mov = 1'b0;
        if (lit_add || (exec_ok_r && !is_lit && opc == `FEPC_OP_ADDWF)) begin
            alu_y = sum[`FEPC_DW-1:0];
            alu_c = sum[`FEPC_DW];
            alu_dc = nsum[4];
            alu_c_upd = 1'b1;
            alu_z_upd = 1'b1;
        end else if (lit_sub || (exec_ok_r && !is_lit && opc == `FEPC_OP_SUBWF)) begin
            sum = {1'b0, opa} + {1'b0, ~acc_operand_r} + 9'h001;
            nsum = {1'b0, opa[3:0]} + {1'b0, ~acc_operand_r[3:0]} + 5'h01;
            alu_y = sum[`FEPC_DW-1:0];
            alu_c = sum[`FEPC_DW];
            alu_dc = nsum[4];
            alu_c_upd = 1'b1;
            alu_z_upd = 1'b1;
        end else if (exec_ok_r && !is_lit) begin
            alu_z_upd = 1'b1;
            case (opc)
                `FEPC_OP_ANDWF: alu_y = opa & acc_operand_r;
                `FEPC_OP_IORWF: alu_y = opa | acc_operand_r;
                `FEPC_OP_XORWF: alu_y = opa ^ acc_operand_r;
                `FEPC_OP_MOVF: alu_y = opa;
                `FEPC_OP_COMF: alu_y = ~opa;
                `FEPC_OP_RRF: begin
                    alu_y = {status_r[`FEPC_ST_C], opa[7:1]};
                    alu_c = opa[0];
                    alu_c_upd = 1'b1;
                    alu_z_upd = 1'b0;
                end
                `FEPC_OP_RLF: begin
                    alu_y = {opa[6:0], status_r[`FEPC_ST_C]};
                    alu_c = opa[7];
                    alu_c_upd = 1'b1;
                    alu_z_upd = 1'b0;
                end
                `FEPC_OP_MOVWF: begin
                    alu_y = acc_operand_r;
                    alu_z_upd = 1'b0;
                    alu_mov = dest_f;
                end
                default: alu_z_upd = 1'b0;
            endcase
        end
        alu_wr = reg_ok && (dest_f || alu_mov) && (opc != `FEPC_OP_NOP || alu_mov);
    end
    // a write to the counter's low byte is a branch, so it must not race the vector
    wire pcl_wr = alu_wr && (faddr == `FEPC_FA_PCL);

    ////////////////////////////////////////////////////////////////////////
    // sequencing
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prog_counter_r <= `FEPC_RESET_VEC;
            pc_latch_r <= `FEPC_RESET_VEC;
            prog_addr_r <= `FEPC_RESET_VEC;
            prog_rd_r <= 1'b0;
            fetch_buf_r <= 14'h0000;
            fetch_ok_r <= 1'b0;
            fetched_word_latch <= 14'h0000;
            exec_ok_r <= 1'b0;
            flush_r <= 1'b0;
            operand_r <= 8'h00;
            data_addr_r <= 7'h00;
            data_rd_r <= 1'b0;
            data_wr_r <= 1'b0;
            data_wdata_r <= 8'h00;
            acc_operand_r <= 8'h00;
            status_r <= 8'h00;
            cycle_rate_output <= 1'b0;
            int_ack_r <= 1'b0;
        end else if (!run_r || !master_reset_n) begin
            prog_counter_r <= `FEPC_RESET_VEC;
            prog_addr_r <= `FEPC_RESET_VEC;
            fetch_ok_r <= 1'b0;
            exec_ok_r <= 1'b0;
            flush_r <= 1'b0;
            prog_rd_r <= 1'b0;
            data_rd_r <= 1'b0;
            data_wr_r <= 1'b0;
            cycle_rate_output <= 1'b0;
            int_ack_r <= 1'b0;
        end else begin
            data_rd_r <= 1'b0;
            data_wr_r <= 1'b0;
            int_ack_r <= 1'b0;
            prog_rd_r <= 1'b0;
            // in rc mode high for phase_three and phase_four, low otherwise
            cycle_rate_output <= rc_mode & (ph2 | phase[`FEPC_PH3]);
            if (ph1) begin
                fetched_word_latch <= fetch_buf_r;
                exec_ok_r <= fetch_ok_r && !flush_r;
                flush_r <= 1'b0;
                prog_addr_r <= prog_counter_r & PC_MASK;
                pc_latch_r <= prog_counter_r;
                prog_counter_r <= (prog_counter_r + 13'h0001) & PC_MASK;
            end
            if (ph2) begin
                data_addr_r <= faddr;
                data_rd_r <= exec_ok_r && !is_lit && !is_jump;
            end
            if (phase[`FEPC_PH3] && data_rd_r)
                operand_r <= file_rd(data_addr_r, pc_latch_r, status_r, data_rdata);
            if (ph4) begin
                prog_rd_r <= 1'b1;
                fetch_buf_r <= prog_rdata;
                fetch_ok_r <= 1'b1;
                if (exec_ok_r) begin
                    if (alu_z_upd) status_r[`FEPC_ST_Z] <= (alu_y == 8'h00);
                    if (alu_c_upd) begin
                        status_r[`FEPC_ST_C] <= alu_c;
                        status_r[`FEPC_ST_DC] <= alu_dc;
                    end
                    if (alu_wr) begin
                        data_wr_r <= 1'b1;
                        data_wdata_r <= alu_y;
                        if (faddr == `FEPC_FA_STATUS) status_r <= alu_y;
                        if (faddr == `FEPC_FA_PCL) begin
                            prog_counter_r <= {pc_latch_r[12:8], alu_y} & PC_MASK;
                            flush_r <= 1'b1;
                        end
                    end else if (lit_ok || (reg_ok && opc != `FEPC_OP_NOP)) begin
                        acc_operand_r <= alu_y;
                    end
                    if (is_jump) begin
                        prog_counter_r <= {pc_latch_r[12:11], fetched_word_latch[10:0]} &
                            PC_MASK;
                        flush_r <= 1'b1;
                    end
                end
                if (int_request && !flush_r && !is_jump && !pcl_wr) begin
                    prog_counter_r <= `FEPC_INT_VEC;
                    flush_r <= 1'b1;
                    int_ack_r <= 1'b1;
                end
            end
        end
    end
endmodule // fepc_core

// file: shared/fepc_defs.vh
// Purpose: constants for the fetch/execute pipeline core
// Assumes: plain Verilog-2005 include
// Notes: phase codes are one-hot positions of the quarter-cycle strobes
`ifndef FEPC_DEFS_VH
`define FEPC_DEFS_VH
`define FEPC_PHASE_W 2
`define FEPC_PH1 2'h0
`define FEPC_PH2 2'h1
`define FEPC_PH3 2'h2
`define FEPC_PH4 2'h3
`define FEPC_PC_W 13
`define FEPC_IW 14
`define FEPC_DW 8
`define FEPC_FA_W 7
`define FEPC_RESET_VEC 13'h0000
`define FEPC_INT_VEC 13'h0004
// special function register file addresses
`define FEPC_FA_PCL 7'h02
`define FEPC_FA_STATUS 7'h03
`define FEPC_FA_PCLATH 7'h0a
// status bit positions
`define FEPC_ST_C 0
`define FEPC_ST_DC 1
`define FEPC_ST_Z 2
// instruction field layout
`define FEPC_OP_HI 13
`define FEPC_OP_LO 8
`define FEPC_DBIT 7
// opcode classes (bits 13:8); jump and literal use the listed prefixes
`define FEPC_OP_NOP 6'h00
`define FEPC_OP_MOVWF 6'h00
`define FEPC_OP_SUBWF 6'h02
`define FEPC_OP_ANDWF 6'h05
`define FEPC_OP_IORWF 6'h04
`define FEPC_OP_XORWF 6'h06
`define FEPC_OP_ADDWF 6'h07
`define FEPC_OP_MOVF 6'h08
`define FEPC_OP_COMF 6'h09
`define FEPC_OP_RRF 6'h0c
`define FEPC_OP_RLF 6'h0d
`define FEPC_OP_MOVLW 6'h30
`define FEPC_OP_ADDLW 6'h3e
`define FEPC_OP_SUBLW 6'h3c
// opcode bits that select a literal operation; the others are don't-care
`define FEPC_LIT_MOV_CARE 6'h3c
`define FEPC_LIT_ARI_CARE 6'h3e
`define FEPC_JUMP_PFX 3'h5
`define FEPC_CYC_NS 200
`define FEPC_CLK_NS 20
`endif

// file: rtl/fepc_phase_gen.v
// Purpose: divide-by-four phase strobe generator
// Assumes: one clock, async active-low reset
// Notes: idle while run is low so the first strobe after release is phase_one
`timescale 1ns/1ns
`include "fepc_defs.vh"
module fepc_phase_gen (
    input wire clk,
    input wire reset_n,
    input wire run,
    output reg [3:0] phase_r
);
    reg [`FEPC_PHASE_W-1:0] cnt_r;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= `FEPC_PH1;
            phase_r <= 4'h0;
        end else if (!run) begin
            cnt_r <= `FEPC_PH1;
            phase_r <= 4'h0;
        end else begin
            phase_r <= 4'h1 << cnt_r;
            cnt_r <= cnt_r + 2'h1;
        end
    end
endmodule // fepc_phase_gen

// file: test/fepc_mem_model.sv
// Purpose: program and data memory arrays beside the core
// Assumes: combinational reads, write on the clock after the write pulse
// Notes: program array is 16 words, the bench programs stay below that
`timescale 1ns/1ns
`include "fepc_defs.vh"
module fepc_mem_model (
    input wire clk,
    input wire [`FEPC_PC_W-1:0] prog_addr_r,
    input wire [`FEPC_FA_W-1:0] data_addr_r,
    input wire data_wr_r,
    input wire [`FEPC_DW-1:0] data_wdata_r,
    output wire [`FEPC_IW-1:0] prog_rdata,
    output wire [`FEPC_DW-1:0] data_rdata
);
    reg [`FEPC_IW-1:0] prog_mem [0:15];
    reg [`FEPC_DW-1:0] data_mem [0:127];
    integer i;
    initial begin
        for (i = 0; i < 128; i = i + 1) data_mem[i] = 8'h00;
    end
    // whole word on its own bus, independent of the data side
    assign prog_rdata = prog_mem[prog_addr_r[3:0]];
    assign data_rdata = data_mem[data_addr_r];
    always @(posedge clk) begin
        if (data_wr_r) data_mem[data_addr_r] <= data_wdata_r;
    end
endmodule // fepc_mem_model

// file: test/fepc_checker.sv
// Purpose: port timing checks of the pipeline core
// Assumes: one clock domain
// Notes: master clear mutes the checks, it restarts the phases
`timescale 1ns/1ns
module fepc_checker (
    input wire clk,
    input wire reset_n,
    input wire master_reset_n,
    input wire rc_mode,
    input wire [12:0] prog_addr_r,
    input wire prog_rd_r,
    input wire data_rd_r,
    input wire data_wr_r,
    input wire cycle_rate_output,
    input wire int_ack_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n || !master_reset_n);
    sequence s_rate;
        ##1 cycle_rate_output ##1 !cycle_rate_output ##1 !cycle_rate_output ##1 cycle_rate_output;
    endsequence
    sequence s_quiet3;
        !prog_rd_r [*3];
    endsequence
    property p_rate;
        ($rose(cycle_rate_output) && rc_mode) |-> s_rate;
    endproperty
    a_rate: assert property (p_rate) else $error("cycle rate not a quarter");
    property p_rate_off;
        !rc_mode [*2] |-> !cycle_rate_output;
    endproperty
    a_rate_off: assert property (p_rate_off) else $error("rate output outside rc");
    property p_pc_hold;
        $changed(prog_addr_r) |=> $stable(prog_addr_r) [*3];
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved inside a cycle");
    property p_fetch;
        prog_rd_r |=> s_quiet3 ##1 prog_rd_r;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch not every four clocks");
    property p_rd_once;
        data_rd_r |=> !data_rd_r [*3];
    endproperty
    a_rd_once: assert property (p_rd_once) else $error("two reads in a cycle");
    property p_wr_once;
        data_wr_r |=> !data_wr_r [*3];
    endproperty
    a_wr_once: assert property (p_wr_once) else $error("two writes in a cycle");
    property p_wrap;
        prog_addr_r[12:11] == 2'b00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pc beyond program memory");
    property p_vec;
        $rose(int_ack_r) |-> ##[0:4] prog_addr_r == 13'h0004;
    endproperty
    a_vec: assert property (p_vec) else $error("no vector after ack");
    property p_ack;
        int_ack_r |=> !int_ack_r [*3];
    endproperty
    a_ack: assert property (p_ack) else $error("ack longer than a pulse");
endmodule // fepc_checker
bind fepc_core fepc_checker fepc_checker_i (.clk(clk), .reset_n(reset_n),
    .master_reset_n(master_reset_n), .rc_mode(rc_mode), .prog_addr_r(prog_addr_r),
    .prog_rd_r(prog_rd_r), .data_rd_r(data_rd_r), .data_wr_r(data_wr_r),
    .cycle_rate_output(cycle_rate_output), .int_ack_r(int_ack_r));

// file: test/tb.sv
// Purpose: self-checking bench of the pipeline core
// Assumes: memory model answers combinationally
// Notes: inputs move on the falling edge; queues log every change
`timescale 1ns/1ns
`include "fepc_defs.vh"
module tb;
    reg clk = 1'b0;
    reg reset_n = 1'b0;
    reg master_reset_n = 1'b1;
    reg rc_mode = 1'b0;
    reg int_request = 1'b0;
    wire [13:0] prog_rdata;
    wire [7:0] data_rdata, data_wdata_r, acc_operand_r, status_r;
    wire [12:0] prog_addr_r;
    wire [6:0] data_addr_r;
    wire prog_rd_r, data_rd_r, data_wr_r, cycle_rate_output, int_ack_r;
    integer fail_count = 0;
    integer checks_done = 0;
    integer cyc = 0;
    integer i, n;
    reg [7:0] wq[$];
    reg [2:0] sq[$];
    reg [12:0] aq[$];
    integer tq[$];
    reg [7:0] w_prev = 8'h00;
    reg [2:0] s_prev = 3'h0;
    reg [12:0] a_prev = 13'h0000;
    reg c_prev;
    always #10 clk = ~clk;
    fepc_core #(.PROG_AW(11)) fepc_core_i (.clk(clk), .reset_n(reset_n),
        .master_reset_n(master_reset_n), .rc_mode(rc_mode), .int_request(int_request),
        .prog_rdata(prog_rdata), .data_rdata(data_rdata), .prog_addr_r(prog_addr_r),
        .prog_rd_r(prog_rd_r), .data_addr_r(data_addr_r), .data_rd_r(data_rd_r),
        .data_wr_r(data_wr_r), .data_wdata_r(data_wdata_r),
        .cycle_rate_output(cycle_rate_output), .acc_operand_r(acc_operand_r),
        .status_r(status_r), .int_ack_r(int_ack_r));
    fepc_mem_model fepc_mem_model_i (.clk(clk), .prog_addr_r(prog_addr_r),
        .data_addr_r(data_addr_r), .data_wr_r(data_wr_r), .data_wdata_r(data_wdata_r),
        .prog_rdata(prog_rdata), .data_rdata(data_rdata));
    ////////////////////////////////////////////////////////////////////////////////
    // pre-edge values only, so the log never races the design's updates
    always @(posedge clk) begin
        cyc = cyc + 1;
        // outputs stay unknown until the first reset edge, so nothing is logged in reset
        if (reset_n) begin
            if (acc_operand_r !== w_prev) wq.push_back(acc_operand_r);
            if (status_r[2:0] !== s_prev) sq.push_back(status_r[2:0]);
            if (prog_addr_r !== a_prev) begin
                aq.push_back(prog_addr_r);
                tq.push_back(cyc);
            end
            w_prev = acc_operand_r;
            s_prev = status_r[2:0];
            a_prev = prog_addr_r;
        end
    end
    task check(input [63:0] got, input [63:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        begin
            for (i = 0; i < 16; i = i + 1) fepc_mem_model_i.prog_mem[i] = 14'h0000;
            fepc_mem_model_i.prog_mem[0] = 14'h3055;
            fepc_mem_model_i.prog_mem[1] = 14'h00a0;
            fepc_mem_model_i.prog_mem[2] = 14'h2805;
            fepc_mem_model_i.prog_mem[3] = 14'h30aa;
            fepc_mem_model_i.prog_mem[4] = 14'h3011;
            fepc_mem_model_i.prog_mem[5] = 14'h3c55;
            fepc_mem_model_i.prog_mem[6] = 14'h00a1;
            fepc_mem_model_i.prog_mem[7] = 14'h3010;
            fepc_mem_model_i.prog_mem[8] = 14'h3c0f;
            fepc_mem_model_i.prog_mem[9] = 14'h3e01;
            fepc_mem_model_i.prog_mem[10] = 14'h0083;
            fepc_mem_model_i.prog_mem[11] = 14'h280a;
            repeat (2) @(negedge clk);
            check(prog_addr_r, 13'h0000);
            check({data_wr_r, prog_rd_r, acc_operand_r}, 10'h000);
            reset_n = 1'b1;
        end
    endtask
    task t_rate;
        begin
            repeat (3) @(negedge clk);
            check(cycle_rate_output, 1'b0);
            rc_mode = 1'b1;
            repeat (4) @(negedge clk);
            n = 0;
            c_prev = cycle_rate_output;
            for (i = 0; i < 40; i = i + 1) begin
                @(negedge clk);
                if (cycle_rate_output && !c_prev) n = n + 1;
                c_prev = cycle_rate_output;
            end
            check(n, 10);
        end
    endtask
    task t_branch;
        begin
            for (i = 0; i < 200 && aq.size() < 4; i = i + 1) @(negedge clk);
            check({aq[0], aq[1], aq[2], aq[3]}, {13'h1, 13'h2, 13'h3, 13'h5});
            check(tq[3] - tq[0], 12);
        end
    endtask
    task t_program;
        begin
            for (i = 0; i < 300 && wq.size() < 5; i = i + 1) @(negedge clk);
            repeat (12) @(negedge clk);
            check(wq.size(), 5);
            check({wq[0], wq[1], wq[2], wq[3], wq[4]}, 40'h55_0010_ff00);
            check({sq[0], sq[1], sq[2]}, 9'h1d7);
            check(sq[3], 3'h0);
            check(fepc_mem_model_i.data_mem[32], 8'h55);
            check(fepc_mem_model_i.data_mem[33], 8'h00);
        end
    endtask
    task t_int;
        begin
            wq.delete();
            int_request = 1'b1;
            for (i = 0; i < 40 && !int_ack_r; i = i + 1) @(negedge clk);
            int_request = 1'b0;
            check(int_ack_r, 1'b1);
            repeat (40) @(negedge clk);
            check({wq[0], wq[1]}, 16'h1144);
            check(fepc_mem_model_i.data_mem[33], 8'h44);
        end
    endtask
    task t_master_reset_n;
        begin
            wq.delete();
            master_reset_n = 1'b0;
            repeat (3) @(negedge clk);
            check(prog_addr_r, 13'h0000);
            master_reset_n = 1'b1;
            for (i = 0; i < 40 && wq.size() < 1; i = i + 1) @(negedge clk);
            check(wq[0], 8'h55);
        end
    endtask
    initial begin
        t_reset;
        t_rate;
        t_branch;
        t_program;
        t_int;
        t_master_reset_n;
        conclude;
    end
    // the whole sequence needs well under 1000 clocks
    initial begin
        #100000;
        fail_count = fail_count + 1;
        conclude;
    end
endmodule // tb
